// ### mcr_cpu_prescaler.sv
// cpu clock prescaler: normal speed or oscillator divided by 2..16
`timescale 1ns/1ps
`default_nettype none
module mcr_cpu_prescaler (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // control
  input wire logic run,
  input wire logic slow_mode_select,
  input wire logic [1:0] slow_divider_select,
  // cpu clock
  output logic cpu_tick,
  output logic cpu_clock
);

  // ratio of the slow clock: 2, 4, 8 or 16
  function automatic logic [4:0] ratio_of(input logic [1:0] code);
    ratio_of = 5'h02 << code;
  endfunction

  logic [4:0] ratio; // current division ratio
  logic [3:0] cnt_q; // position within one cpu period
  logic [3:0] cnt_d;
  logic last; // final oscillator cycle of the period

  always_comb begin
    ratio = ratio_of(slow_divider_select);
    last = ({1'b0, cnt_q} == ratio - 5'h01);
    cnt_d = last ? 4'h0 : cnt_q + 4'h1;
  end

  // period counter; cleared to zero while the oscillator is stopped or at normal speed
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      cnt_q <= 4'h0;
    end else if (run && slow_mode_select) begin
      cnt_q <= cnt_d;
    end else begin
      cnt_q <= 4'h0;
    end
  end

  // tick marks each cpu cycle; every oscillator cycle at normal speed
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      cpu_tick <= 1'b0;
    end else if (!run) begin
      cpu_tick <= 1'b0;
    end else if (!slow_mode_select) begin
      cpu_tick <= 1'b1;
    end else begin
      cpu_tick <= (cnt_d == 4'h0);
    end
  end

  // square wave; at normal speed a flop can only show half the rate
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      cpu_clock <= 1'b0;
    end else if (!run) begin
      cpu_clock <= cpu_clock;
    end else if (!slow_mode_select) begin
      cpu_clock <= ~cpu_clock;
    end else begin
      cpu_clock <= ({1'b0, cnt_d} < (ratio >> 1));
    end
  end

endmodule
`default_nettype wire

// ### mcr_main_clock.sv
// main clock controller: prescaler, clock-out, real-time counter, tone
// Operation
// - slow clock is oscillator over 2,4,8,16
// - slow select clear gives full oscillator rate
// - bit 7 puts cpu clock on pin
// - clock-out pin stops during timed halt
// - time base picks 16000..200000 cycle period
// - new time base applies after current period
// - period end sets the timeout flag
// - reads clear flag; writes never set it; a read in timed or full halt leaves the flag set
// - interrupt needs flag, enable, unmasked cpu
// - halt with enable set gives timed halt
// - wait keeps counting; tick wakes it
// - timed halt counts, registers held, tick wakes
// - full halt freezes all until wake
// - tick never wakes from full halt
// - tone pin gives three selectable tones
// - tone codes: off, 2k, 1k, 500 Hz
// - all control bits zero after reset
// - functions run independently and together
//
// Chosen here: the register addresses and the AXI4-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
module mcr_main_clock #(
  parameter int RTC_P0 = mcr_pkg::RTC_PERIOD_0,
  parameter int RTC_P1 = mcr_pkg::RTC_PERIOD_1,
  parameter int RTC_P2 = mcr_pkg::RTC_PERIOD_2,
  parameter int RTC_P3 = mcr_pkg::RTC_PERIOD_3,
  parameter int TONE_H1 = mcr_pkg::TONE_HALF_1,
  parameter int TONE_H2 = mcr_pkg::TONE_HALF_2,
  parameter int TONE_H3 = mcr_pkg::TONE_HALF_3
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // axi4-lite write
  input wire logic [mcr_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read
  input wire logic [mcr_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // core power interface
  input wire logic wait_exec,
  input wire logic halt_exec,
  input wire logic halt_wake,
  input wire logic cpu_irq_mask,
  output mcr_pkg::mcr_pwr_e power_state,
  output logic tick_irq,
  // cpu clock
  output logic cpu_tick,
  output logic cpu_clock,
  // clock-out pin
  output logic clock_out_o,
  output logic clock_out_oe_n,
  // tone pin
  output logic tone_o,
  output logic tone_oe_n
);

  // true when an address equals the given register byte address
  function automatic logic hit(input logic [mcr_pkg::ADDR_W-1:0] a,
                               input logic [mcr_pkg::ADDR_W-1:0] r);
    hit = (a == r);
  endfunction

  // period in oscillator cycles for a time base code
  function automatic logic [mcr_pkg::CNT_W-1:0] period_of(
      input logic [1:0] code);
    unique case (code)
      2'b00: period_of = mcr_pkg::CNT_W'(RTC_P0);
      2'b01: period_of = mcr_pkg::CNT_W'(RTC_P1);
      2'b10: period_of = mcr_pkg::CNT_W'(RTC_P2);
      2'b11: period_of = mcr_pkg::CNT_W'(RTC_P3);
    endcase
  endfunction

  // control/status fields
  logic clock_out_enable; // pin carries cpu clock
  logic [1:0] slow_divider_select;
  logic slow_mode_select;
  logic [1:0] time_base_select; // software view of the time base
  logic tick_irq_enable;
  logic tick_flag; // timeout reached, cleared by a read
  logic [1:0] tone_select;
  logic [7:0] csr_view; // assembled status byte
  // bus state
  logic aw_full_q, w_full_q;
  logic [mcr_pkg::ADDR_W-1:0] aw_addr_q;
  logic [7:0] w_data_q;
  logic w_lane0_q; // low byte lane enabled
  logic wr_fire, rd_fire, rd_clr;
  // real-time counter
  logic [mcr_pkg::CNT_W-1:0] rtc_cnt_q;
  logic [1:0] tb_act_q; // time base in force this period
  logic rtc_end; // last cycle of the period
  // tone
  logic [mcr_pkg::CNT_W-1:0] tone_cnt_q;
  logic [mcr_pkg::CNT_W-1:0] tone_half;
  // power state and derived freezes
  mcr_pkg::mcr_pwr_e pwr_q;
  logic regs_frozen; // software state held
  logic osc_running; // oscillator alive

  assign power_state = pwr_q;
  assign regs_frozen = (pwr_q == mcr_pkg::PWR_AHALT) ||
                       (pwr_q == mcr_pkg::PWR_HALT);
  assign osc_running = (pwr_q != mcr_pkg::PWR_HALT);
  assign csr_view = {clock_out_enable, slow_divider_select,
                     slow_mode_select, time_base_select,
                     tick_irq_enable, tick_flag};

  // interrupt request, gated by enable and the cpu mask
  assign tick_irq = tick_flag && tick_irq_enable && !cpu_irq_mask;

  // write channels are taken independently; one response at a time
  assign s_axi_awready = !aw_full_q;
  assign s_axi_wready = !w_full_q;
  assign wr_fire = aw_full_q && w_full_q && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;
  assign rd_fire = s_axi_arvalid && s_axi_arready;
  // a status read clears the flag, unless the core is halted
  assign rd_clr = rd_fire && !regs_frozen &&
                  hit(s_axi_araddr, mcr_pkg::CSR_ADDR);

  // address and data holding for the write path
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      aw_full_q <= 1'b0;
      w_full_q <= 1'b0;
      aw_addr_q <= '0;
      w_data_q <= 8'h00;
      w_lane0_q <= 1'b0;
    end else begin
      if (wr_fire) begin
        aw_full_q <= 1'b0;
        w_full_q <= 1'b0;
      end else begin
        if (s_axi_awvalid && !aw_full_q) begin
          aw_full_q <= 1'b1;
          aw_addr_q <= s_axi_awaddr;
        end
        if (s_axi_wvalid && !w_full_q) begin
          w_full_q <= 1'b1;
          w_data_q <= s_axi_wdata[7:0];
          w_lane0_q <= s_axi_wstrb[0];
        end
      end
    end
  end

  // write response; unmapped addresses answer with slave error
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= mcr_pkg::RESP_OKAY;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
      if (hit(aw_addr_q, mcr_pkg::CSR_ADDR) ||
          hit(aw_addr_q, mcr_pkg::TONE_ADDR)) begin
        s_axi_bresp <= mcr_pkg::RESP_OKAY;
      end else begin
        s_axi_bresp <= mcr_pkg::RESP_SLVERR;
      end
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // read data, captured before the flag clears
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= mcr_pkg::RESP_OKAY;
    end else if (rd_fire) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= mcr_pkg::RESP_OKAY;
      if (hit(s_axi_araddr, mcr_pkg::CSR_ADDR)) begin
        s_axi_rdata <= {24'h00_0000, csr_view};
      end else if (hit(s_axi_araddr, mcr_pkg::TONE_ADDR)) begin
        s_axi_rdata <= {30'h0000_0000, tone_select};
      end else begin
        s_axi_rdata <= 32'h0000_0000;
        s_axi_rresp <= mcr_pkg::RESP_SLVERR;
      end
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // software-written control bits; held while halted
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      {clock_out_enable, slow_divider_select, slow_mode_select,
       time_base_select, tick_irq_enable} <= mcr_pkg::CSR_RESET[7:1];
      tone_select <= mcr_pkg::TONE_RESET[1:0];
    end else if (wr_fire && w_lane0_q && !regs_frozen) begin
      if (hit(aw_addr_q, mcr_pkg::CSR_ADDR)) begin
        clock_out_enable <= w_data_q[mcr_pkg::CLKOUT_BIT];
        slow_divider_select <= w_data_q[mcr_pkg::DIV_LSB +: 2];
        slow_mode_select <= w_data_q[mcr_pkg::SLOW_BIT];
        time_base_select <= w_data_q[mcr_pkg::TB_LSB +: 2];
        tick_irq_enable <= w_data_q[mcr_pkg::TIE_BIT];
      end
      if (hit(aw_addr_q, mcr_pkg::TONE_ADDR)) begin
        tone_select <= w_data_q[mcr_pkg::TONE_LSB +: 2];
      end
    end
  end

  // timeout flag: hardware set wins over a clearing read
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      tick_flag <= mcr_pkg::CSR_RESET[mcr_pkg::FLAG_BIT];
    end else if (rtc_end) begin
      tick_flag <= 1'b1;
    end else if (rd_clr) begin
      tick_flag <= 1'b0;
    end
  end

  // real-time counter; keeps counting in wait and timed halt
  assign rtc_end = osc_running &&
                   (rtc_cnt_q == period_of(tb_act_q) - 1'b1);

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      rtc_cnt_q <= '0;
      tb_act_q <= 2'b00;
    end else if (!osc_running) begin
      rtc_cnt_q <= rtc_cnt_q;
    end else if (rtc_end) begin
      rtc_cnt_q <= '0;
      tb_act_q <= time_base_select;
    end else begin
      rtc_cnt_q <= rtc_cnt_q + 1'b1;
    end
  end

  // tone half period for the selected code
  always_comb begin
    unique case (tone_select)
      2'b00: tone_half = '0;
      2'b01: tone_half = mcr_pkg::CNT_W'(TONE_H1);
      2'b10: tone_half = mcr_pkg::CNT_W'(TONE_H2);
      2'b11: tone_half = mcr_pkg::CNT_W'(TONE_H3);
    endcase
  end

  // tone square wave at half duty; off code parks the pin low
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      tone_cnt_q <= '0;
      tone_o <= 1'b0;
    end else if (tone_select == 2'b00) begin
      tone_cnt_q <= '0;
      tone_o <= 1'b0;
    end else if (osc_running) begin
      if (tone_cnt_q >= tone_half - 1'b1) begin
        tone_cnt_q <= '0;
        tone_o <= ~tone_o;
      end else begin
        tone_cnt_q <= tone_cnt_q + 1'b1;
      end
    end
  end
  assign tone_oe_n = (tone_select == 2'b00);

  // cpu clock divider, independent of counter and tone
  mcr_cpu_prescaler u_prescaler (
    .core_clk(core_clk),
    .rst(rst),
    .run(osc_running),
    .slow_mode_select(slow_mode_select),
    .slow_divider_select(slow_divider_select),
    .cpu_tick(cpu_tick),
    .cpu_clock(cpu_clock)
  );

  // clock-out pin holds low in timed halt to save power
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      clock_out_o <= 1'b0;
    end else if (pwr_q == mcr_pkg::PWR_AHALT || !clock_out_enable) begin
      clock_out_o <= 1'b0;
    end else begin
      clock_out_o <= cpu_clock;
    end
  end
  assign clock_out_oe_n = !clock_out_enable;

  // power modes of the core as seen by this block
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      pwr_q <= mcr_pkg::PWR_RUN;
    end else begin
      unique case (pwr_q)
        mcr_pkg::PWR_RUN: begin
          if (halt_exec) begin
            pwr_q <= tick_irq_enable ? mcr_pkg::PWR_AHALT
                                     : mcr_pkg::PWR_HALT;
          end else if (wait_exec) begin
            pwr_q <= mcr_pkg::PWR_WAIT;
          end
        end
        mcr_pkg::PWR_WAIT: begin
          if (tick_irq || halt_wake) begin
            pwr_q <= mcr_pkg::PWR_RUN;
          end
        end
        mcr_pkg::PWR_AHALT: begin
          if (tick_irq || halt_wake) begin
            pwr_q <= mcr_pkg::PWR_RUN;
          end
        end
        mcr_pkg::PWR_HALT: begin
          if (halt_wake) begin
            pwr_q <= mcr_pkg::PWR_RUN;
          end
        end
      endcase
    end
  end

  // checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  sequence seq_halt_with_tie;
    pwr_q == mcr_pkg::PWR_RUN && halt_exec && tick_irq_enable;
  endsequence
  sequence seq_full_halt_idle;
    pwr_q == mcr_pkg::PWR_HALT && !halt_wake;
  endsequence

  chk_flag_on_end: assert property (
    rtc_end |=> tick_flag)
    else $error("flag not set at period end");
  chk_read_clears: assert property (
    rd_clr && !rtc_end |=> !tick_flag)
    else $error("status read left flag set");
  chk_write_no_set: assert property (
    !tick_flag && !rtc_end |=> !tick_flag)
    else $error("flag set without period end");
  chk_irq_gating: assert property (
    rtc_end && tick_irq_enable && !wr_fire |=> tick_irq || cpu_irq_mask)
    else $error("interrupt not raised at period end");
  chk_halt_choice: assert property (
    seq_halt_with_tie |=> pwr_q == mcr_pkg::PWR_AHALT)
    else $error("halt with enable did not give timed halt");
  chk_halt_freeze: assert property (
    seq_full_halt_idle ##1 pwr_q == mcr_pkg::PWR_HALT
      |-> $stable(rtc_cnt_q) && $stable(csr_view[7:1]))
    else $error("state moved in full halt");
  chk_tick_no_wake: assert property (
    seq_full_halt_idle |=> pwr_q == mcr_pkg::PWR_HALT)
    else $error("left full halt without wake");
  chk_ahalt_counts: assert property (
    pwr_q == mcr_pkg::PWR_AHALT && !rtc_end
      |=> rtc_cnt_q == $past(rtc_cnt_q) + 1'b1)
    else $error("counter stalled in timed halt");
  chk_tb_deferred: assert property (
    !rtc_end |=> $stable(tb_act_q))
    else $error("time base changed mid period");
  chk_rtc_restart: assert property (
    rtc_end |=> rtc_cnt_q == '0)
    else $error("counter did not restart");
  chk_clkout_quiet: assert property (
    pwr_q == mcr_pkg::PWR_AHALT [*2] |-> !clock_out_o)
    else $error("clock out toggling in timed halt");

endmodule
`default_nettype wire

// ### mcr_pkg.sv
// constants and types shared by the main clock controller files
package mcr_pkg;

  // register indices; byte address is four times the index
  localparam logic [7:0] CSR_INDEX = 8'h2C;
  localparam logic [7:0] TONE_INDEX = 8'h2D;
  localparam int ADDR_W = 10;
  localparam logic [9:0] CSR_ADDR = {CSR_INDEX, 2'b00};
  localparam logic [9:0] TONE_ADDR = {TONE_INDEX, 2'b00};

  // control/status field positions
  localparam int CLKOUT_BIT = 7;
  localparam int DIV_LSB = 5;
  localparam int SLOW_BIT = 4;
  localparam int TB_LSB = 2;
  localparam int TIE_BIT = 1;
  localparam int FLAG_BIT = 0;
  localparam int TONE_LSB = 0;

  // reset values
  localparam logic [7:0] CSR_RESET = 8'h00;
  localparam logic [7:0] TONE_RESET = 8'h00;

  // real-time counter periods in oscillator cycles
  localparam int RTC_PERIOD_0 = 16000;
  localparam int RTC_PERIOD_1 = 32000;
  localparam int RTC_PERIOD_2 = 80000;
  localparam int RTC_PERIOD_3 = 200000;
  localparam int CNT_W = 18;

  // tone frequencies, given for a reference oscillator rate
  localparam int OSC_REF_HZ = 8000000;
  localparam int TONE_HZ_1 = 2000;
  localparam int TONE_HZ_2 = 1000;
  localparam int TONE_HZ_3 = 500;
  localparam int TONE_HALF_1 = OSC_REF_HZ / (2 * TONE_HZ_1);
  localparam int TONE_HALF_2 = OSC_REF_HZ / (2 * TONE_HZ_2);
  localparam int TONE_HALF_3 = OSC_REF_HZ / (2 * TONE_HZ_3);

  // bus responses
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  // power modes of the core
  typedef enum logic [1:0] {
    PWR_RUN = 2'b00,
    PWR_WAIT = 2'b01,
    PWR_AHALT = 2'b10,
    PWR_HALT = 2'b11
  } mcr_pwr_e;

endpackage

// ### tb.sv
// self-checking testbench for the main clock controller
`timescale 1ns/1ps
`default_nettype none
module tb;
  // shortened counts keep the run brief; expectations use these
  localparam int per[4] = '{16, 32, 80, 200};
  localparam int half[4] = '{0, 4, 8, 16};
  // clock, reset and bus wires
  logic core_clk, rst;
  logic [9:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic s_axi_rvalid, s_axi_rready;
  // core power side and pins
  logic wait_exec, halt_exec, halt_wake, cpu_irq_mask, tick_irq;
  mcr_pkg::mcr_pwr_e power_state;
  logic cpu_tick, cpu_clock, clock_out_o, clock_out_oe_n, tone_o, tone_oe_n;
  // bookkeeping
  int error_cnt = 0;
  int check_count = 0;
  int cyc = 0;
  logic [31:0] rd;
  logic [1:0] rr, wr;
  localparam logic [9:0] CSR = mcr_pkg::CSR_ADDR;
  localparam logic [9:0] TONE = mcr_pkg::TONE_ADDR;

  mcr_main_clock #(.RTC_P0(per[0]), .RTC_P1(per[1]), .RTC_P2(per[2]),
    .RTC_P3(per[3]), .TONE_H1(half[1]), .TONE_H2(half[2]),
    .TONE_H3(half[3])) dut (
    .core_clk, .rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .wait_exec, .halt_exec, .halt_wake, .cpu_irq_mask,
    .power_state, .tick_irq, .cpu_tick, .cpu_clock, .clock_out_o,
    .clock_out_oe_n, .tone_o, .tone_oe_n);

  // 40 mhz oscillator clock
  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end
  // free cycle count, used to time flag periods
  always @(posedge core_clk) cyc <= cyc + 1;

  // verdict and exit, the only place the run ends
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  // four-state compare, so an unknown never matches
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // a wait that ran out counts as a mismatch and stops the run
  task automatic tmo();
    error_cnt++;
    $display("mismatch at %0t: wait ran out", $time);
    end_of_test();
  endtask

  // bus write: address and data offered together, held until taken
  task automatic axw(input logic [9:0] a, input logic [7:0] d);
    int n;
    @(posedge core_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h00_0000, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge core_clk);
      if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid === 1'b1) break;
    end
    if (n == 50) tmo();
    wr = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask

  // bus read: response taken at the edge that shows rvalid
  task automatic axr(input logic [9:0] a);
    int n;
    @(posedge core_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge core_clk);
      if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid === 1'b1) break;
    end
    if (n == 50) tmo();
    rd = s_axi_rdata;
    rr = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask

  // waits for the tick request and notes the cycle it showed
  task automatic wait_irq(output int t);
    int n;
    for (n = 0; n < 400 && tick_irq !== 1'b1; n++) @(posedge core_clk);
    if (tick_irq !== 1'b1) tmo();
    t = cyc;
  endtask

  // one-cycle wait or halt instruction pulse from the core
  task automatic pulse(input bit h);
    @(posedge core_clk);
    if (h) halt_exec <= 1'b1;
    else wait_exec <= 1'b1;
    @(posedge core_clk);
    halt_exec <= 1'b0;
    wait_exec <= 1'b0;
    @(posedge core_clk);
  endtask

  // reset values and an unmapped place
  task automatic t_reset();
    axr(CSR);
    check(rd, 32'h0000_0000);
    axr(TONE);
    check(rd, 32'h0000_0000);
    check({clock_out_oe_n, tone_oe_n}, 32'h0000_0003);
    check(power_state, mcr_pkg::PWR_RUN);
    axw(10'h000, 8'hFF);
    check(wr, mcr_pkg::RESP_SLVERR);
    axr(10'h3FC);
    check(rr, mcr_pkg::RESP_SLVERR);
    check(rd, 32'h0000_0000);
    // low byte lane disabled: write answered but register untouched
    s_axi_wstrb <= 4'h0;
    axw(TONE, 8'h03);
    s_axi_wstrb <= 4'hF;
    check(wr, mcr_pkg::RESP_OKAY);
    axr(TONE);
    check(rd, 32'h0000_0000);
    $display("test reset done");
  endtask

  // flag period for every time base code, then a mid-period change
  task automatic t_period();
    int t, t2;
    for (int k = 0; k < 4; k++) begin
      axw(CSR, {4'h0, 2'(k), 2'b10});
      wait_irq(t);
      axr(CSR);
      wait_irq(t);
      axr(CSR);
      check(rd[0], 1'b1);
      wait_irq(t2);
      axr(CSR);
      check(t2 - t, per[k]);
    end
    // longest base running; switch to shortest just after a period end
    wait_irq(t);
    axr(CSR);
    axw(CSR, 8'h03);
    axr(CSR);
    check(rd, 32'h0000_0002);
    wait_irq(t2);
    check(t2 - t, per[3]);
    axr(CSR);
    $display("test period done");
  endtask

  // masked request, flag read then cleared by the read
  task automatic t_mask();
    cpu_irq_mask <= 1'b1;
    axw(CSR, 8'h02);
    axr(CSR);
    repeat (40) @(posedge core_clk);
    check(tick_irq, 1'b0);
    axr(CSR);
    check(rd[0], 1'b1);
    axr(CSR);
    check(rd[0], 1'b0);
    cpu_irq_mask <= 1'b0;
    $display("test mask done");
  endtask

  // slow mode tick spacing per divider code, normal speed after
  task automatic t_prescale();
    int n;
    int m;
    logic c;
    for (int k = 0; k < 4; k++) begin
      axw(CSR, {1'b0, 2'(k), 1'b1, 4'h0});
      for (n = 0; n < 40 && cpu_tick !== 1'b1; n++) @(posedge core_clk);
      n = 0;
      do begin
        @(posedge core_clk);
        n++;
      end while (cpu_tick !== 1'b1 && n < 40);
      check(n, 2 << k);
    end
    axw(CSR, 8'h00);
    n = 0;
    m = 0;
    c = cpu_clock;
    repeat (8) begin
      @(posedge core_clk);
      n += int'(cpu_tick === 1'b1);
      m += int'(cpu_clock !== c);
      c = cpu_clock;
    end
    check(n, 8);
    check(m, 8);
    $display("test prescale done");
  endtask

  // tone half periods while clock-out and slow mode also run
  task automatic t_tone();
    int n;
    logic v, seen;
    axw(CSR, 8'hF0);
    check(clock_out_oe_n, 1'b0);
    seen = 1'b0;
    repeat (40) begin
      @(posedge core_clk);
      seen |= (clock_out_o === 1'b1);
    end
    check(seen, 1'b1);
    for (int k = 1; k < 4; k++) begin
      axw(TONE, 8'(k));
      check(tone_oe_n, 1'b0);
      v = tone_o;
      for (n = 0; n < 40 && tone_o === v; n++) @(posedge core_clk);
      v = tone_o;
      for (n = 0; n < 40 && tone_o === v; n++) @(posedge core_clk);
      check(n, half[k]);
    end
    axw(TONE, 8'h00);
    repeat (2) @(posedge core_clk);
    check({tone_oe_n, tone_o}, 32'h0000_0002);
    axw(CSR, 8'h00);
    $display("test tone done");
  endtask

  // wait, timed halt and full halt entry and exit
  task automatic t_power();
    int n, bad;
    axw(CSR, 8'h02);
    axr(CSR);
    pulse(1'b0);
    check(power_state, mcr_pkg::PWR_WAIT);
    for (n = 0; n < 60 && power_state == mcr_pkg::PWR_WAIT; n++)
      @(posedge core_clk);
    check(power_state, mcr_pkg::PWR_RUN);
    axw(CSR, 8'h82);
    axr(CSR);
    pulse(1'b1);
    check(power_state, mcr_pkg::PWR_AHALT);
    bad = 0;
    for (n = 0; n < 60 && power_state == mcr_pkg::PWR_AHALT; n++) begin
      @(posedge core_clk);
      bad += int'(clock_out_o !== 1'b0);
    end
    check(bad, 0);
    check(power_state, mcr_pkg::PWR_RUN);
    axw(CSR, 8'h00);
    pulse(1'b1);
    check(power_state, mcr_pkg::PWR_HALT);
    axw(CSR, 8'h1E);
    bad = 0;
    repeat (100) begin
      @(posedge core_clk);
      bad += int'(power_state != mcr_pkg::PWR_HALT || cpu_tick !== 1'b0);
    end
    check(bad, 0);
    halt_wake <= 1'b1;
    repeat (2) @(posedge core_clk);
    halt_wake <= 1'b0;
    check(power_state, mcr_pkg::PWR_RUN);
    axr(CSR);
    check(rd & 32'h0000_00FE, 32'h0000_0000);
    $display("test power done");
  endtask

  // reset, then the scenarios in turn
  initial begin
    rst = 1'b1;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    s_axi_wstrb = 4'hF;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
    {s_axi_arvalid, s_axi_rready} = '0;
    {wait_exec, halt_exec, halt_wake, cpu_irq_mask} = '0;
    repeat (6) @(posedge core_clk);
    rst <= 1'b0;
    t_reset();
    t_period();
    t_mask();
    t_prescale();
    t_tone();
    t_power();
    end_of_test();
  end
endmodule
`default_nettype wire
